// [common/shb_pkg.sv]
// Package: field positions, reset values, timing and carrier types for the serial control block
package shb_pkg;
	localparam int CMD_W = 16;
	localparam int NUM_OUT = 6;
	localparam int BIT_CLR = 0;
	localparam int BIT_SW_LO = 1;
	localparam int BIT_SW_HI = 12;
	localparam int BIT_OLD_N = 13;
	localparam int BIT_DELAY = 14;
	localparam int BIT_SOFT_EN = 15;
	localparam int ST_PREWARN = 0;
	localparam int ST_SHORT = 13;
	localparam int ST_ENABLE = 14;
	localparam int ST_SUPPLY = 15;
	localparam logic [15:0] CMD_RESET = 16'he000;
	localparam logic [15:0] ALL_ONES = 16'hffff;
	localparam logic [3:0] BIT_CNT_MAX = 4'hf;
	localparam int CLK_MHZ = 10;
	localparam int DELAY_LONG_US = 12000;
	localparam int DELAY_SHORT_US = 1500;
	localparam int DELAY_LONG_CYC = DELAY_LONG_US * CLK_MHZ;
	localparam int DELAY_SHORT_CYC = DELAY_SHORT_US * CLK_MHZ;

	typedef struct packed {
		logic soft_enable;
		logic short_delay_select;
		logic open_load_check_n;
		logic [11:0] switches;
		logic status_clear;
	} shb_cmd_t;

	typedef struct packed {
		logic [11:0] over_current;
		logic [11:0] open_load;
		logic over_temp;
		logic temp_prewarn;
		logic supply_fail;
	} shb_sense_t;
endpackage

// [verilog/shb_serial_ctrl.sv]
// Serial command and status interface of the six half-bridge driver
`timescale 1ns/10ps
// Overview of operation
// - Chip select falling starts a new frame.
// - New command takes effect only at chip select rising.
// - Data-in sampled on each falling serial clock edge.
// - Data-out driven while chip select low, released while high.
// - Data-out changes on rising serial clock, stable until next rise.
// - Status goes out LSB first; bit 0 is temperature pre-warning.
// - Command bit 0 clears supply-fail, short and over-temperature flags.
// - Bits 1..12 switch low and high sides; odd low, even high.
// - Bit 13 low enables open-load detection.
// - Bit 14 picks shutdown delay: high 12 ms, low 1.5 ms.
// - Bit 15 software enable; low is standby, serial still works.
// - Hardware enable low means standby.
// - Fault pin pulled low on over-temperature or over-current.
// - Status 1..12 output or open load, 13 short, 14 enable, 15 supply.
// - Over-temperature flag returns all sixteen status bits high; outputs stay as commanded.
// - Reset command: soft enable, delay select, open-load-off high.
// - Either enable low turns all outputs off; serial stays active.
module shb_serial_ctrl #(
	parameter int DELAY_LONG = shb_pkg::DELAY_LONG_CYC,
	parameter int DELAY_SHORT = shb_pkg::DELAY_SHORT_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic chip_sel_n,
	input wire logic serial_clk,
	input wire logic serial_in,
	input wire logic hw_enable,
	input wire shb_pkg::shb_sense_t sense,
	output logic serial_out,
	output logic serial_out_oe,
	output logic fault_n_out,
	output logic fault_n_oe,
	output logic [shb_pkg::NUM_OUT-1:0] low_switch_on,
	output logic [shb_pkg::NUM_OUT-1:0] high_switch_on,
	output logic open_load_enable,
	output logic status_clear_pulse
);
	localparam int CNT_W = $clog2(DELAY_LONG + 1);

	logic [2:0] cs_s_r, sck_s_r, din_s_r, en_s_r;
	logic [shb_pkg::NUM_OUT*2-1:0] sense_s1_r, sense_s2_r;
	logic [2:0] flag_s1_r, flag_s2_r;
	logic [shb_pkg::NUM_OUT*2-1:0] ol_s1_r, ol_s2_r;
	logic [15:0] shift_in_r, shift_in_nxt;
	logic [15:0] shift_out_r, shift_out_nxt;
	logic [3:0] bit_cnt_r;
	shb_pkg::shb_cmd_t cmd_r, cmd_nxt;
	logic [11:0] tripped_r;
	logic [CNT_W-1:0] oc_cnt_r [12];
	logic short_flag_r, supply_fail_r, over_temp_r;

	// Synchronisers: first stage read only by the second
	always_ff @(posedge clk) begin
		cs_s_r <= {cs_s_r[1:0], chip_sel_n};
		sck_s_r <= {sck_s_r[1:0], serial_clk};
		din_s_r <= {din_s_r[1:0], serial_in};
		en_s_r <= {en_s_r[1:0], hw_enable};
		sense_s1_r <= sense.over_current;
		sense_s2_r <= sense_s1_r;
		flag_s1_r <= {sense.over_temp, sense.supply_fail, sense.temp_prewarn};
		flag_s2_r <= flag_s1_r;
		ol_s1_r <= sense.open_load;
		ol_s2_r <= ol_s1_r;
	end

	// Pin edges seen in the clock domain
	wire cs_low = ~cs_s_r[1];
	wire cs_fall = cs_s_r[2] & ~cs_s_r[1];
	wire cs_rise = ~cs_s_r[2] & cs_s_r[1];
	wire sck_fall = cs_low & sck_s_r[2] & ~sck_s_r[1];
	wire sck_rise = cs_low & ~sck_s_r[2] & sck_s_r[1];
	wire din_bit = din_s_r[1];
	wire hw_en = en_s_r[1];
	// Enables, clear and over-current gating
	wire run_en = cmd_r.soft_enable & hw_en;
	wire clear_now = cs_rise & shift_in_r[shb_pkg::BIT_CLR];
	wire delay_sel = cmd_r.short_delay_select;
	wire [CNT_W-1:0] delay_lim = delay_sel ? CNT_W'(DELAY_LONG) : CNT_W'(DELAY_SHORT);
	wire [11:0] sw_on = cmd_r.switches & ~tripped_r & {12{run_en}};
	wire [11:0] oc_now = sense_s2_r;

	// Status word assembly
	wire [11:0] sw_stat = cmd_r.open_load_check_n ? sw_on : ol_s2_r;
	wire [15:0] status_word = over_temp_r ? shb_pkg::ALL_ONES :
		{supply_fail_r, run_en, short_flag_r, sw_stat, flag_s2_r[0]};

	// LSB-first shifters
	assign shift_in_nxt = sck_fall ? {din_bit, shift_in_r[15:1]} : shift_in_r;
	assign shift_out_nxt = cs_fall ? status_word :
		(sck_rise && bit_cnt_r != 4'h0) ? {1'b0, shift_out_r[15:1]} : shift_out_r;
	assign cmd_nxt = cs_rise ? shb_pkg::shb_cmd_t'(shift_in_r) : cmd_r;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			shift_in_r <= 16'h0000;
			shift_out_r <= 16'h0000;
			bit_cnt_r <= 4'h0;
			cmd_r <= shb_pkg::shb_cmd_t'(shb_pkg::CMD_RESET);
		end else begin
			shift_in_r <= cs_fall ? 16'h0000 : shift_in_nxt;
			shift_out_r <= shift_out_nxt;
			cmd_r <= cmd_nxt;
			if (cs_fall)
				bit_cnt_r <= 4'h0;
			else if (sck_rise && bit_cnt_r != shb_pkg::BIT_CNT_MAX)
				bit_cnt_r <= bit_cnt_r + 4'h1;
		end
	end

	// Over-current timers per switch
	genvar g;
	generate
		for (g = 0; g < 12; g++) begin : g_oc
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					oc_cnt_r[g] <= '0;
					tripped_r[g] <= 1'b0;
				end else begin
					if (!(oc_now[g] && sw_on[g]))
						oc_cnt_r[g] <= '0;
					else if (oc_cnt_r[g] < delay_lim)
						oc_cnt_r[g] <= oc_cnt_r[g] + CNT_W'(1);
					if (oc_now[g] && sw_on[g] && oc_cnt_r[g] >= delay_lim - CNT_W'(1))
						tripped_r[g] <= 1'b1;
					else if (clear_now)
						tripped_r[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// Sticky flags: set wins over clear for supply and over-temperature, clear wins for short
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			short_flag_r <= 1'b0;
			supply_fail_r <= 1'b0;
			over_temp_r <= 1'b0;
		end else begin
			// Short flag drops with the tripped switches it reports
			short_flag_r <= ((|tripped_r) | short_flag_r) & ~clear_now;
			supply_fail_r <= flag_s2_r[1] | (supply_fail_r & ~clear_now);
			over_temp_r <= flag_s2_r[2] | (over_temp_r & ~clear_now);
		end
	end

	// Registered outputs
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			serial_out <= 1'b0;
			serial_out_oe <= 1'b0;
			fault_n_out <= 1'b0;
			fault_n_oe <= 1'b0;
			low_switch_on <= '0;
			high_switch_on <= '0;
			open_load_enable <= 1'b0;
			status_clear_pulse <= 1'b0;
		end else begin
			serial_out <= shift_out_nxt[0];
			serial_out_oe <= cs_low;
			fault_n_out <= 1'b0;
			fault_n_oe <= over_temp_r | short_flag_r;
			for (int i = 0; i < shb_pkg::NUM_OUT; i++) begin
				low_switch_on[i] <= sw_on[2*i];
				high_switch_on[i] <= sw_on[2*i+1];
			end
			open_load_enable <= ~cmd_r.open_load_check_n;
			status_clear_pulse <= clear_now;
		end
	end

	// Checks
	a_cmd_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!cs_rise |=> cmd_r == $past(cmd_r)) else $error("command changed outside cs rise");
	a_do_release: assert property (@(posedge clk) disable iff (sys_rst)
		!cs_low |=> !serial_out_oe) else $error("data-out driven while deselected");
	a_do_stable: assert property (@(posedge clk) disable iff (sys_rst)
		(cs_low && !sck_rise && !cs_fall) |=> $stable(serial_out)) else $error("data-out moved");
	a_load_status: assert property (@(posedge clk) disable iff (sys_rst)
		cs_fall |=> shift_out_r == $past(status_word)) else $error("status not loaded");
	a_standby_off: assert property (@(posedge clk) disable iff (sys_rst)
		!run_en |=> (low_switch_on == '0 && high_switch_on == '0)) else $error("output in standby");
	a_fault_pin: assert property (@(posedge clk) disable iff (sys_rst)
		over_temp_r |=> fault_n_oe && !fault_n_out) else $error("fault not pulled");
	a_ot_ones: assert property (@(posedge clk) disable iff (sys_rst)
		over_temp_r |-> status_word == shb_pkg::ALL_ONES) else $error("overtemp word wrong");
	a_clear_flags: assert property (@(posedge clk) disable iff (sys_rst)
		(clear_now && !flag_s2_r[1]) |=> !supply_fail_r) else $error("supply flag kept");
	a_sample_in: assert property (@(posedge clk) disable iff (sys_rst)
		(sck_fall && !cs_fall) |=> shift_in_r[15] == $past(din_bit)) else $error("bit missed");

	// Output and protection checks
	a_ls_cmd: assert property (@(posedge clk) disable iff (sys_rst)
		low_switch_on[0] |-> $past(cmd_r.switches[0] && run_en)) else $error("low side on");
	a_hs_cmd: assert property (@(posedge clk) disable iff (sys_rst)
		high_switch_on[0] |-> $past(cmd_r.switches[1] && run_en)) else $error("high side on");
	a_trip_hold: assert property (@(posedge clk) disable iff (sys_rst)
		(tripped_r[0] && !clear_now) |=> tripped_r[0]) else $error("trip released");
	a_ol_enable: assert property (@(posedge clk) disable iff (sys_rst)
		1'b1 |=> open_load_enable == !$past(cmd_r.open_load_check_n)) else $error("open-load");
	a_clear_pulse: assert property (@(posedge clk) disable iff (sys_rst)
		1'b1 |=> status_clear_pulse == $past(clear_now)) else $error("clear pulse wrong");
	a_oe_drive: assert property (@(posedge clk) disable iff (sys_rst)
		cs_low |=> serial_out_oe) else $error("data-out not driven");
	a_short_fault: assert property (@(posedge clk) disable iff (sys_rst)
		short_flag_r |=> fault_n_oe) else $error("fault not pulled on short");
	a_short_clear: assert property (@(posedge clk) disable iff (sys_rst)
		clear_now |=> !short_flag_r) else $error("short flag kept");
	a_hw_standby: assert property (@(posedge clk) disable iff (sys_rst)
		!hw_en |=> (low_switch_on == '0 && high_switch_on == '0)) else $error("hw standby");
	a_soft_standby: assert property (@(posedge clk) disable iff (sys_rst)
		!cmd_r.soft_enable |=> (low_switch_on == '0 && high_switch_on == '0)) else $error("sw");
	a_en_status: assert property (@(posedge clk) disable iff (sys_rst)
		!over_temp_r |-> status_word[shb_pkg::ST_ENABLE] == run_en) else $error("enable bit");
	a_prewarn_bit: assert property (@(posedge clk) disable iff (sys_rst)
		!over_temp_r |-> status_word[shb_pkg::ST_PREWARN] == flag_s2_r[0]) else $error("prewarn");
endmodule

// [tb/shb_host.sv]
// Host controller model that clocks frames through the serial port
`timescale 1ns/10ps
module shb_host (
	input wire logic clk,
	output logic chip_sel_n,
	output logic serial_clk,
	output logic serial_in,
	input wire logic serial_out
);
	initial begin
		chip_sel_n = 1'h1;
		serial_clk = 1'h0;
		serial_in = 1'h0;
	end
	task automatic frame(input logic [15:0] cmd, output logic [15:0] st);
		chip_sel_n <= 1'h0;
		repeat (8) @(posedge clk);
		for (int i = 0; i < 16; i++) begin
			serial_clk <= 1'h1;
			serial_in <= cmd[i];
			repeat (4) @(posedge clk);
			serial_clk <= 1'h0;
			repeat (4) @(posedge clk);
			st[i] = serial_out;
		end
		chip_sel_n <= 1'h1;
		serial_in <= ~serial_in;
		repeat (8) @(posedge clk);
	endtask
endmodule

// [tb/shb_serial_ctrl_tb_top.sv]
// Self-checking bench for the serial control block
`timescale 1ns/10ps
module shb_serial_ctrl_tb_top;
	typedef struct packed {
		logic [15:0] cmd;
		logic hw;
		shb_pkg::shb_sense_t sense;
		logic [15:0] st;
		logic flt;
	} shb_row_t;
	logic clk, sys_rst, chip_sel_n, serial_clk, serial_in, hw_enable;
	shb_pkg::shb_sense_t sense;
	logic serial_out, serial_out_oe, fault_n_out, fault_n_oe, open_load_enable;
	logic [5:0] low_switch_on, high_switch_on, lo, hi;
	logic [15:0] st, prev;
	int bad_count, check_count, clr_seen;
	logic status_clear_pulse;
	wire fault_pin = fault_n_oe ? fault_n_out : 1'h1;
	shb_row_t rows [5] = '{
		{16'heaaa, 1'h1, 27'h0, 16'h4aaa, 1'h0},
		{16'h3554, 1'h1, 27'h2, 16'h0001, 1'h0},
		{16'h9554, 1'h0, 27'h78, 16'h001e, 1'h0},
		{16'he000, 1'h1, 27'h5, 16'hffff, 1'h1},
		{16'hf555, 1'h1, 27'h0, 16'h5554, 1'h0}};
	shb_serial_ctrl #(.DELAY_LONG(20), .DELAY_SHORT(5)) i_shb_serial_ctrl (.clk(clk),
		.sys_rst(sys_rst), .chip_sel_n(chip_sel_n), .serial_clk(serial_clk),
		.serial_in(serial_in), .hw_enable(hw_enable), .sense(sense),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe), .fault_n_out(fault_n_out),
		.fault_n_oe(fault_n_oe), .low_switch_on(low_switch_on),
		.high_switch_on(high_switch_on), .open_load_enable(open_load_enable),
		.status_clear_pulse(status_clear_pulse));
	always @(posedge clk) begin
		if (status_clear_pulse === 1'h1)
			clr_seen++;
	end
	shb_host i_shb_host (.clk(clk), .chip_sel_n(chip_sel_n), .serial_clk(serial_clk),
		.serial_in(serial_in), .serial_out(serial_out));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		if (bad_count == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	initial begin
		#1000000;
		bad_count++;
		end_of_test();
	end
	initial begin
		sys_rst = 1'h1;
		hw_enable = 1'h1;
		sense = '0;
		prev = 16'h0;
		repeat (8) @(posedge clk);
		sys_rst <= 1'h0;
		repeat (4) @(posedge clk);
		chk({4'h0, low_switch_on, high_switch_on}, 16'h0);
		chk({15'h0, open_load_enable}, 16'h0);
		for (int r = 0; r < 5; r++) begin
			sense <= rows[r].sense;
			fork
				i_shb_host.frame(rows[r].cmd, st);
				begin
					repeat (70) @(posedge clk);
					chk({4'h0, low_switch_on, high_switch_on}, prev);
					chk({15'h0, serial_out_oe}, 16'h1);
				end
			join
			hw_enable <= rows[r].hw;
			repeat (6) @(posedge clk);
			for (int k = 0; k < 6; k++) begin
				lo[k] = rows[r].cmd[15] & rows[r].hw & rows[r].cmd[2*k+1];
				hi[k] = rows[r].cmd[15] & rows[r].hw & rows[r].cmd[2*k+2];
			end
			prev = {4'h0, lo, hi};
			chk({15'h0, serial_out_oe}, 16'h0);
			chk({4'h0, low_switch_on, high_switch_on}, prev);
			chk({15'h0, open_load_enable}, {15'h0, ~rows[r].cmd[13]});
			i_shb_host.frame(rows[r].cmd, st);
			chk(st, rows[r].st);
			chk({15'h0, fault_pin}, {15'h0, ~rows[r].flt});
		end
		sense <= 27'h8000;
		i_shb_host.frame(16'he002, st);
		chk({4'h0, low_switch_on, high_switch_on}, 16'h0040);
		repeat (10) @(posedge clk);
		chk({4'h0, low_switch_on, high_switch_on}, 16'h0040);
		repeat (15) @(posedge clk);
		chk({4'h0, low_switch_on, high_switch_on}, 16'h0);
		chk({15'h0, fault_pin}, 16'h0);
		i_shb_host.frame(16'ha003, st);
		chk(st, 16'h6000);
		chk({4'h0, low_switch_on, high_switch_on}, 16'h0040);
		repeat (10) @(posedge clk);
		chk({4'h0, low_switch_on, high_switch_on}, 16'h0);
		sense <= '0;
		i_shb_host.frame(16'ha003, st);
		chk(st, 16'h6000);
		chk({15'h0, fault_pin}, 16'h1);
		chk({4'h0, low_switch_on, high_switch_on}, 16'h0040);
		i_shb_host.frame(16'ha002, st);
		chk(st, 16'h4002);
		chk(clr_seen[15:0], 16'h4);
		sys_rst <= 1'h1;
		repeat (8) @(posedge clk);
		sys_rst <= 1'h0;
		repeat (4) @(posedge clk);
		chk({4'h0, low_switch_on, high_switch_on}, 16'h0);
		chk({15'h0, open_load_enable}, 16'h0);
		i_shb_host.frame(16'he000, st);
		chk(st, 16'h4000);
		end_of_test();
	end
endmodule
